// ### hw/wdp_pkg.sv
package wdp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] WAKE_CONTROL_ADDR = 16'h0454;
  localparam logic [7:0]  WAKE_CONTROL_RST  = 8'h00;
  localparam int          WAKE_EN_BIT       = 0;
  localparam int          INT_BLOCK_BIT     = 1;
  localparam logic [7:0]  WAKE_CONTROL_MASK = 8'h03;

  // ----------------------------------------------------------------
  // Interrupt mode field of the digital port control register
  // ----------------------------------------------------------------
  localparam int         MODE_LSB     = 3;
  localparam int         MODE_MSB     = 4;
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_STROBE  = 2'h1;
  localparam logic [1:0] MODE_EVENT   = 2'h2;
  localparam logic [1:0] MODE_MATCH   = 2'h3;

  // ----------------------------------------------------------------
  // Sample rates
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ   = 125_000_000;
  localparam int FAST_HZ      = 8_330_000;
  localparam int SLOW_HZ      = 32_000;
  localparam int FAST_DIV     = REF_CLK_HZ / FAST_HZ;
  localparam int SLOW_DIV     = REF_CLK_HZ / SLOW_HZ;

  typedef enum logic [1:0] {
    WDP_IDLE,
    WDP_ARMED,
    WDP_WAKING
  } wdp_state_type;

endpackage

// ### hw/wdp_sample_if.sv
`timescale 1ns/1ps
interface wdp_sample_if;
  logic       slow_sel;
  logic       tick;
  modport ctrl (output slow_sel, input tick);
  modport gen  (input slow_sel, output tick);
endinterface

// ### hw/wdp_tick_gen.sv
`timescale 1ns/1ps
module wdp_tick_gen #(
  parameter int FAST_DIV = wdp_pkg::FAST_DIV,
  parameter int SLOW_DIV = wdp_pkg::SLOW_DIV
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  // Sample rate control
  wdp_sample_if.gen  smp
);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  localparam int CW = $clog2(SLOW_DIV + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] limit;
  logic          tick_q;
  logic          tick_d;

  always_comb begin
    limit = smp.slow_sel ? CW'(SLOW_DIV - 1) : CW'(FAST_DIV - 1);
    // Restart on any rate change edge is not needed: wrap at the new limit
    if (cnt_q >= limit) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d  = cnt_q + CW'(1);
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign smp.tick = tick_q;

endmodule

// ### hw/wdp_wake_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Strobe, match or event condition can wake.
// - Wake request reaches every power-down state.
// - Wake enable bit in control register 0x454.
// - Standby samples port on slow 32 kHz.
// - Block bit high passes interrupt, wake set by bit0.
// - Enable and block decode per four-row table.
// - Bit0 wake enable, bit1 interrupt block.
// - Mode bits 4:3 pick strobe, event, match.
module wdp_wake_ctrl #(
  parameter int WIDTH    = 8,
  parameter int FAST_DIV = wdp_pkg::FAST_DIV,
  parameter int SLOW_DIV = wdp_pkg::SLOW_DIV
) (
  // Clock, reset, enable
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  input  wire logic             CE,
  // I/O register port
  input  wire logic [15:0]      IO_ADDR,
  input  wire logic             IO_WR,
  input  wire logic             IO_RD,
  input  wire logic [7:0]       IO_WDATA,
  output logic      [7:0]       IO_RDATA,
  // Port configuration from the digital port control register
  input  wire logic [7:0]       DIGITAL_PORT_CONTROL,
  input  wire logic [WIDTH-1:0] MATCH_MASK,
  input  wire logic [WIDTH-1:0] MATCH_VALUE,
  input  wire logic             IRQ_CLEAR,
  // Port pins
  input  wire logic [WIDTH-1:0] PORT_IN,
  input  wire logic             STROBE_IN,
  // Power state
  input  wire logic             STANDBY,
  // Results
  output logic                  PORT_IRQ,
  output logic                  WAKE_EVENT,
  output logic                  SLOW_SAMPLING
);

  // ----------------------------------------------------------------
  // Wake control register
  // ----------------------------------------------------------------
  logic [7:0] wctl_q;
  logic [7:0] wctl_d;
  logic       hit;

  assign hit = (IO_ADDR == wdp_pkg::WAKE_CONTROL_ADDR);

  always_comb begin
    wctl_d = wctl_q;
    if (IO_WR && hit) begin
      wctl_d = IO_WDATA & wdp_pkg::WAKE_CONTROL_MASK;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wctl_q <= wdp_pkg::WAKE_CONTROL_RST;
    end else if (CE) begin
      wctl_q <= wctl_d;
    end
  end

  // Reserved bits always read zero
  always_comb begin
    IO_RDATA = 8'h00;
    if (IO_RD && hit) begin
      IO_RDATA = wctl_q;
    end
  end

  // ----------------------------------------------------------------
  // Sample clock
  // ----------------------------------------------------------------
  wdp_sample_if smp ();

  assign smp.slow_sel  = STANDBY;
  assign SLOW_SAMPLING = STANDBY;

  wdp_tick_gen #(
    .FAST_DIV (FAST_DIV),
    .SLOW_DIV (SLOW_DIV)
  ) u_tick (
    .clk (REF_CLK),
    .rst (RST),
    .ce  (CE),
    .smp (smp)
  );

  // ----------------------------------------------------------------
  // Port sampling and deglitch
  // ----------------------------------------------------------------
  // Two agreeing samples are needed, so a glitch shorter than one
  // sample period is dropped; in standby this is why inputs must
  // hold for tens of microseconds.
  logic [WIDTH-1:0] s0_q, s0_d;
  logic [WIDTH-1:0] s1_q, s1_d;
  logic [WIDTH-1:0] stab_q, stab_d;
  logic             st0_q, st0_d;
  logic             st1_q, st1_d;
  logic             stst_q, stst_d;
  logic             cond_q, cond_d;
  logic             prim_q, prim_d;
  logic             warm_q, warm_d;
  logic [1:0]       mode;
  logic             raw;

  assign mode = DIGITAL_PORT_CONTROL[wdp_pkg::MODE_MSB:wdp_pkg::MODE_LSB];

  always_comb begin
    s0_d   = s0_q;
    s1_d   = s1_q;
    stab_d = stab_q;
    st0_d  = st0_q;
    st1_d  = st1_q;
    stst_d = stst_q;
    warm_d = warm_q;
    raw    = 1'b0;
    if (smp.tick && !warm_q) begin
      // First sample seeds every stage: a port idling high after
      // reset must not look like an edge or an event
      s0_d   = PORT_IN;
      s1_d   = PORT_IN;
      stab_d = PORT_IN;
      st0_d  = STROBE_IN;
      st1_d  = STROBE_IN;
      stst_d = STROBE_IN;
      warm_d = 1'b1;
    end else if (smp.tick) begin
      s0_d  = PORT_IN;
      s1_d  = s0_q;
      st0_d = STROBE_IN;
      st1_d = st0_q;
      if (s0_q == s1_q) begin
        stab_d = s1_q;
      end
      if (st0_q == st1_q) begin
        stst_d = st1_q;
      end
      unique case (mode)
        wdp_pkg::MODE_OFF:    raw = 1'b0;
        wdp_pkg::MODE_STROBE: raw = (st0_q == st1_q) && st1_q && !stst_q;
        wdp_pkg::MODE_EVENT:  raw = (s0_q == s1_q) && (((s1_q ^ stab_q) & ~MATCH_MASK) != '0)
                                    && (MATCH_MASK != '1);
        wdp_pkg::MODE_MATCH:  raw = (s0_q == s1_q) && (((s1_q ^ MATCH_VALUE) & ~MATCH_MASK) == '0)
                                    && (MATCH_MASK != '1);
      endcase
    end
  end

  // sticky port condition, set wins over clear
  always_comb begin
    prim_d = smp.tick ? raw : prim_q;
    cond_d = cond_q;
    if (IRQ_CLEAR) begin
      cond_d = 1'b0;
    end
    if (raw && !(mode == wdp_pkg::MODE_MATCH && prim_q)) begin
      cond_d = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s0_q   <= '0;
      s1_q   <= '0;
      stab_q <= '0;
      st0_q  <= 1'b0;
      st1_q  <= 1'b0;
      stst_q <= 1'b0;
      cond_q <= 1'b0;
      prim_q <= 1'b0;
      warm_q <= 1'b0;
    end else if (CE) begin
      s0_q   <= s0_d;
      s1_q   <= s1_d;
      stab_q <= stab_d;
      st0_q  <= st0_d;
      st1_q  <= st1_d;
      stst_q <= stst_d;
      cond_q <= cond_d;
      prim_q <= prim_d;
      warm_q <= warm_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and wake decode
  // ----------------------------------------------------------------
  logic irq_q, irq_d;
  logic wake_q, wake_d;
  logic wen, blk;

  assign wen = wctl_q[wdp_pkg::WAKE_EN_BIT];
  assign blk = wctl_q[wdp_pkg::INT_BLOCK_BIT];

  always_comb begin
    // table decode: block bit high passes the interrupt
    // covered by the 1-0 row: wake without interrupt
    irq_d  = cond_d && blk;
    wake_d = cond_d && wen;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else if (CE) begin
      irq_q  <= irq_d;
      wake_q <= wake_d;
    end
  end

  assign PORT_IRQ   = irq_q;
  assign WAKE_EVENT = wake_q;

endmodule

// ### sim/wdp_wake_ctrl_asserts.sv
`timescale 1ns/1ps
module wdp_wake_ctrl_asserts (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        CE,
  // Register port and control
  input wire logic [15:0] IO_ADDR,
  input wire logic        IO_WR,
  input wire logic        IO_RD,
  input wire logic [7:0]  IO_WDATA,
  input wire logic [7:0]  IO_RDATA,
  input wire logic [7:0]  DIGITAL_PORT_CONTROL,
  input wire logic        IRQ_CLEAR,
  input wire logic        STANDBY,
  // Results
  input wire logic        PORT_IRQ,
  input wire logic        WAKE_EVENT,
  input wire logic        SLOW_SAMPLING
);
  // ------------------------------------------------
  // Shadow of the wake control bits
  // ------------------------------------------------
  logic [1:0] wc_q;
  logic [1:0] wc_d;
  logic       hit;
  assign hit = IO_ADDR == wdp_pkg::WAKE_CONTROL_ADDR;
  always_comb begin
    wc_d = wc_q;
    if (CE && IO_WR && hit) wc_d = IO_WDATA[1:0];
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) wc_q <= 2'h0;
    else wc_q <= wc_d;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_slow; SLOW_SAMPLING == STANDBY; endproperty
  a_slow: assert property (p_slow) else $error("sample rate not following standby");
  property p_fast; $fell(STANDBY) |-> !SLOW_SAMPLING; endproperty
  a_fast: assert property (p_fast) else $error("slow sampling kept after standby");
  property p_unmapped; IO_RD && !hit |-> IO_RDATA == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("other address answered");
  property p_readback; IO_RD && hit |-> IO_RDATA == {6'h00, wc_q}; endproperty
  a_readback: assert property (p_readback) else $error("wake control readback");
  property p_wake_src; $rose(WAKE_EVENT) |-> wc_q[0] || $past(wc_q[0]); endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake without enable");
  property p_irq_src; $rose(PORT_IRQ) |-> wc_q[1] || $past(wc_q[1]); endproperty
  a_irq_src: assert property (p_irq_src) else $error("interrupt while blocked");
  property p_both; $rose(WAKE_EVENT) && $past(wc_q) == 2'h3 |-> PORT_IRQ; endproperty
  a_both: assert property (p_both) else $error("interrupt missing with wake");
  property p_hold; WAKE_EVENT && wc_q[0] && !IRQ_CLEAR && !IO_WR |=> WAKE_EVENT; endproperty
  a_hold: assert property (p_hold) else $error("wake dropped early");
  // Enable already on two edges back: the rise came from a fresh port condition
  property p_mode;
    $rose(WAKE_EVENT) && $past(wc_q[0], 2) |-> $past(DIGITAL_PORT_CONTROL[4:3]) != 2'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("wake with mode off");
  property p_freeze; !CE |=> $stable(PORT_IRQ) && $stable(WAKE_EVENT); endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  c_standby_wake: cover property (WAKE_EVENT && STANDBY);
  c_irq_only: cover property (PORT_IRQ && !WAKE_EVENT);
  c_both: cover property (PORT_IRQ && WAKE_EVENT);
endmodule
bind wdp_wake_ctrl wdp_wake_ctrl_asserts wdp_wake_ctrl_asserts_inst (.REF_CLK(REF_CLK),
  .RST(RST), .CE(CE), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
  .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .DIGITAL_PORT_CONTROL(DIGITAL_PORT_CONTROL),
  .IRQ_CLEAR(IRQ_CLEAR), .STANDBY(STANDBY), .PORT_IRQ(PORT_IRQ),
  .WAKE_EVENT(WAKE_EVENT), .SLOW_SAMPLING(SLOW_SAMPLING));

// ### sim/wdp_port_src.sv
`timescale 1ns/1ps
module wdp_port_src #(
  parameter int HOLD = 16
) (
  // Bench request
  input wire logic       clk,
  input wire logic [7:0] want,
  input wire logic       want_stb,
  // Connector lines
  output logic     [7:0] pins,
  output logic           stb
);
  // ------------------------------------------------
  // Outside lines, slow enough for standby sampling
  // ------------------------------------------------
  int cnt = 0;
  initial begin
    pins = 8'h00;
    stb = 1'b0;
  end
  always @(posedge clk) begin
    if (cnt > 0) cnt <= cnt - 1;
    else if (want !== pins || want_stb !== stb) begin
      pins <= want;
      stb <= want_stb;
      cnt <= HOLD;
    end
  end
endmodule

// ### sim/tb_wake_on_digital_input.sv
`timescale 1ns/1ps
module tb_wake_on_digital_input;
  // ------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------
  localparam int FDIV = 2;
  localparam int SDIV = 8;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, stb_w = 0, sb = 0, clr = 0, ce = 1;
  int          lat = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wd = 8'h00, ctl = 8'h00, mv = 8'h00, want = 8'h00, v, pins, rdat;
  logic        stb, irq, wake, slow;
  int          miscompares = 0, check_count = 0;
  initial forever #4 clk = ~clk;
  // Short dividers keep the standby cases brief
  wdp_wake_ctrl #(.FAST_DIV(FDIV), .SLOW_DIV(SDIV)) wdp_wake_ctrl_inst (.REF_CLK(clk), .RST(rst),
    .CE(ce), .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd), .IO_WDATA(wd), .IO_RDATA(rdat),
    .DIGITAL_PORT_CONTROL(ctl), .MATCH_MASK(8'h00), .MATCH_VALUE(mv), .IRQ_CLEAR(clr),
    .PORT_IN(pins), .STROBE_IN(stb), .STANDBY(sb), .PORT_IRQ(irq), .WAKE_EVENT(wake),
    .SLOW_SAMPLING(slow));
  wdp_port_src #(.HOLD(3 * SDIV)) wdp_port_src_inst (.clk(clk), .want(want), .want_stb(stb_w),
    .pins(pins), .stb(stb));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic io_wr(input logic [7:0] d);
    addr = wdp_pkg::WAKE_CONTROL_ADDR;
    wd = d;
    wr = 1;
    step(1);
    wr = 0;
    step(1);
  endtask
  task automatic io_rd(input logic [15:0] a, input logic [7:0] e);
    addr = a;
    rd = 1;
    #2;
    chk(rdat, e);
    step(1);
    rd = 0;
    step(1);
  endtask
  // Interrupt in bit 1, wake in bit 0
  function automatic logic [7:0] expect_out(input logic [1:0] w);
    return {6'h00, w[1], w[0]};
  endfunction
  // Three samples per detection: fast ticks bound the wait above, slow ticks below
  function automatic logic rate_ok(input int n, input logic s);
    return s ? (n >= 2 * SDIV + 2) : (n <= 3 * FDIV + 2);
  endfunction
  task automatic complete_run;
    $display("miscompares %0d checks %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(48));
    step(3);
    rst = 0;
    io_rd(wdp_pkg::WAKE_CONTROL_ADDR, 8'h00);
    io_wr(8'hFF);
    io_rd(wdp_pkg::WAKE_CONTROL_ADDR, 8'h03);
    io_rd(16'h0455, 8'h00);
    ce = 0;
    io_wr(8'h00);
    ce = 1;
    io_rd(wdp_pkg::WAKE_CONTROL_ADDR, 8'h03);
    for (int m = 1; m < 4; m++) begin
      for (int w = 0; w < 4; w++) begin
        v = want ^ 8'($urandom_range(1, 255));
        mv = v;
        ctl = 8'(m << 3);
        clr = 1;
        step(1);
        clr = 0;
        io_wr(8'(w));
        sb = (m == 3) || (w == 3);
        step(20);
        want = v;
        stb_w = 1;
        for (lat = 0; lat < 120 && !(irq || wake); lat++) step(1);
        step(2);
        chk({6'h00, irq, wake}, expect_out(2'(w)));
        chk({7'h00, slow}, {7'h00, sb});
        if (w != 0) chk({7'h00, rate_ok(lat, sb)}, 8'h01);
        sb = 0;
        stb_w = 0;
        ctl = 8'h00;
        step(1);
        chk({7'h00, slow}, 8'h00);
        step(20);
      end
    end
    rst = 1;
    step(1);
    rst = 0;
    io_rd(wdp_pkg::WAKE_CONTROL_ADDR, 8'h00);
    chk({6'h00, irq, wake}, 8'h00);
    complete_run;
  end
  initial begin
    #50000;
    miscompares++;
    complete_run;
  end
endmodule
